// ==== core/isc_pkg.sv ====
package isc_pkg;

  // ----------------------------------------------------------------
  // widths and array geometry
  // ----------------------------------------------------------------
  localparam int PTR_W = 11;
  localparam int ADC_W = 10;
  localparam int ROWS_DEF = 1024;
  localparam int COLS_DEF = 1280;
  localparam int WB_AW = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [WB_AW-1:0] ADR_STATUS = 8'h00;
  localparam logic [WB_AW-1:0] ADR_LAST_ROW = 8'h04;
  localparam logic [WB_AW-1:0] ADR_LAST_COL = 8'h08;
  localparam logic [WB_AW-1:0] ADR_ROW_PTR = 8'h0c;
  localparam logic [WB_AW-1:0] ADR_COL_PTR = 8'h10;
  localparam logic [WB_AW-1:0] ADR_AMP = 8'h14;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] LAST_ROW_RST = 11'h3ff;
  localparam logic [PTR_W-1:0] LAST_COL_RST = 11'h4ff;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_EOS_POS = 0;
  localparam int ST_VALID_POS = 3;
  localparam int ST_LR_POS = 6;
  localparam int ST_INV_POS = 7;
  localparam int ROWPTR_LEFT_POS = 16;
  localparam int AMP_GAIN_POS = 0;
  localparam int AMP_OFFS_POS = 4;
  localparam int AMP_FLAG_POS = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic right_row_clock;
    logic right_row_sync_n;
    logic left_row_clock;
    logic left_row_sync_n;
    logic col_clock;
    logic col_sync_n;
    logic left_right_sel;
    logic amp_ext_sel;
    logic [3:0] gain_word;
    logic unity_gain;
    logic fast_cal;
    logic slow_cal;
    logic [3:0] black_offset;
    logic track_hold;
    logic col_cal;
    logic bit_invert;
  } isc_pins_s;

  typedef struct packed {
    logic ext_sel;
    logic [3:0] gain_word;
    logic unity;
    logic fast_cal;
    logic st2_to_dac;
    logic st1_to_out;
    logic [3:0] black_offset;
  } isc_amp_s;

  typedef enum logic [1:0] {
    PTR_PARK,
    PTR_RUN,
    PTR_EOS,
    PTR_DONE
  } isc_ptr_state_e;

endpackage

// ==== core/isc_sync.sv ====
`timescale 1ns/10ps
module isc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import isc_pkg::*;

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // ----------------------------------------------------------------
  // two-stage synchroniser, one per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        meta_nxt[i] = d_i[i];
        q_nxt[i] = meta_r[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule

// ==== core/isc_scan_ptr.sv ====
`timescale 1ns/10ps
module isc_scan_ptr #(
  parameter int W = 11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fall_i,
  input wire logic sync_n_i,
  input wire logic [W-1:0] last_i,
  output logic [W-1:0] ptr_o,
  output logic valid_o,
  output logic eos_n_o
);
  import isc_pkg::*;

  isc_ptr_state_e st_r;
  isc_ptr_state_e st_nxt;
  logic [W-1:0] ptr_r;
  logic [W-1:0] ptr_nxt;
  logic eos_n_r;
  logic eos_n_nxt;

  always_comb begin
    st_nxt = st_r;
    ptr_nxt = ptr_r;
    eos_n_nxt = eos_n_r;
    if (!sync_n_i) begin
      st_nxt = PTR_PARK;
      ptr_nxt = '0;
      eos_n_nxt = 1'b1;
    end else if (fall_i) begin
      case (st_r)
        PTR_PARK: begin
          st_nxt = PTR_RUN;
          ptr_nxt = '0;
        end
        PTR_RUN: begin
          if (ptr_r == last_i) begin
            st_nxt = PTR_EOS;
            eos_n_nxt = 1'b0;
          end else begin
            ptr_nxt = ptr_r + 1'b1;
          end
        end
        PTR_EOS: begin
          // end-of-scan lasts exactly one pin-clock period
          st_nxt = PTR_DONE;
          eos_n_nxt = 1'b1;
        end
        PTR_DONE: st_nxt = PTR_DONE;
        default: st_nxt = PTR_PARK;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= PTR_PARK;
      ptr_r <= '0;
      eos_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ptr_r <= ptr_nxt;
      eos_n_r <= eos_n_nxt;
    end
  end

  assign ptr_o = ptr_r;
  assign valid_o = (st_r == PTR_RUN);
  assign eos_n_o = eos_n_r;
endmodule

// ==== core/isc_ctrl_top.sv ====
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
// Functional notes
// [R01] pointers advance on falling edges of their own pin clocks
// [R02] right row sync low holds the right row pointer in reset
// [R03] column sync low holds the column pointer in reset
// [R04] right row end-of-scan low for first right clock after last row
// [R05] left row end-of-scan low for first left clock after last row
// [R06] column end-of-scan low for first column clock after last column
// [R07] input select high routes external input, low the imager core
// [R08] four gain pins form one word, first pin least significant
// [R09] unity gain high overrides the gain word
// [R10] fast dark calibration runs while its input is high
// [R11] slow calibration low: cap and inverting input; high: dac and output
// [R12] four offset pins form the black level word, bit 3 most significant
// [R13] column sample holds while track/hold is high, tracks when low
// [R14] column amplifiers calibrate while column calibration is high
// [R15] bit inversion high inverts the digital output word
// [R16] left/right select chooses readout versus shutter row pointer
// [R17] controller sets exposure by delay between the two row syncs
// [R18] controller keeps row clock running between frames for shutter
// [R19] released pointer selects first line on next falling clock edge
// [R20] controller keeps gain, offset and selects stable during lines
module isc_ctrl_top #(
  parameter int ROWS = isc_pkg::ROWS_DEF,
  parameter int COLS = isc_pkg::COLS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [isc_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire isc_pkg::isc_pins_s pins_i,
  input wire logic [isc_pkg::ADC_W-1:0] adc_word_i,
  output logic right_row_end_of_scan_n_o,
  output logic left_row_end_of_scan_n_o,
  output logic col_end_of_scan_n_o,
  output logic [isc_pkg::PTR_W-1:0] right_row_ptr_o,
  output logic [isc_pkg::PTR_W-1:0] left_row_ptr_o,
  output logic [isc_pkg::PTR_W-1:0] col_ptr_o,
  output logic [isc_pkg::PTR_W-1:0] readout_row_o,
  output logic [isc_pkg::PTR_W-1:0] shutter_row_o,
  output logic readout_row_valid_o,
  output logic shutter_row_valid_o,
  output logic col_valid_o,
  output isc_pkg::isc_amp_s amp_o,
  output logic col_hold_o,
  output logic col_cal_o,
  output logic [isc_pkg::ADC_W-1:0] data_word_o
);
  import isc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] LAST_ROW_DEF = PTR_W'(ROWS - 1);
  localparam logic [PTR_W-1:0] LAST_COL_DEF = PTR_W'(COLS - 1);

  isc_pins_s pins_s;
  logic [2:0] clk_now;
  logic [2:0] clk_prev_r;
  logic [2:0] clk_prev_nxt;
  logic [2:0] fall;

  logic [PTR_W-1:0] r_ptr;
  logic [PTR_W-1:0] l_ptr;
  logic [PTR_W-1:0] c_ptr;
  logic r_valid;
  logic l_valid;
  logic c_valid;
  logic r_eos_n;
  logic l_eos_n;
  logic c_eos_n;

  logic [PTR_W-1:0] last_row_r;
  logic [PTR_W-1:0] last_row_nxt;
  logic [PTR_W-1:0] last_col_r;
  logic [PTR_W-1:0] last_col_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic [31:0] rd_mux;
  logic wr_take;

  isc_amp_s amp_r;
  isc_amp_s amp_nxt;
  logic hold_r;
  logic hold_nxt;
  logic cal_r;
  logic cal_nxt;
  logic [ADC_W-1:0] data_r;
  logic [ADC_W-1:0] data_nxt;
  logic [PTR_W-1:0] rd_row_r;
  logic [PTR_W-1:0] rd_row_nxt;
  logic [PTR_W-1:0] sh_row_r;
  logic [PTR_W-1:0] sh_row_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic sh_valid_r;
  logic sh_valid_nxt;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every pin from the sequencer is asynchronous to clk_i
  isc_sync #(
    .W($bits(isc_pins_s))
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_i),
    .q_o(pins_s)
  );

  // ----------------------------------------------------------------
  // falling edge detect on pin clocks
  // ----------------------------------------------------------------
  // pin clocks must stay well below clk_i/4 for edges to be seen
  assign clk_now = {pins_s.col_clock, pins_s.left_row_clock, pins_s.right_row_clock};

  always_comb begin
    clk_prev_nxt = clk_now;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prev_r <= '0;
    end else begin
      clk_prev_r <= clk_prev_nxt;
    end
  end

  // [R01] falling edge strobe
  assign fall = clk_prev_r & ~clk_now;

  // ----------------------------------------------------------------
  // pointer registers
  // ----------------------------------------------------------------
  // [R02] [R04] [R19] right row pointer
  isc_scan_ptr #(
    .W(PTR_W)
  ) u_right_row (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fall_i(fall[0]),
    .sync_n_i(pins_s.right_row_sync_n),
    .last_i(last_row_r),
    .ptr_o(r_ptr),
    .valid_o(r_valid),
    .eos_n_o(r_eos_n)
  );

  // [R05] [R19] left row pointer, same row geometry
  isc_scan_ptr #(
    .W(PTR_W)
  ) u_left_row (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fall_i(fall[1]),
    .sync_n_i(pins_s.left_row_sync_n),
    .last_i(last_row_r),
    .ptr_o(l_ptr),
    .valid_o(l_valid),
    .eos_n_o(l_eos_n)
  );

  // [R03] [R06] [R19] column pointer
  isc_scan_ptr #(
    .W(PTR_W)
  ) u_col (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fall_i(fall[2]),
    .sync_n_i(pins_s.col_sync_n),
    .last_i(last_col_r),
    .ptr_o(c_ptr),
    .valid_o(c_valid),
    .eos_n_o(c_eos_n)
  );

  // ----------------------------------------------------------------
  // readout / shutter steering
  // ----------------------------------------------------------------
  always_comb begin
    // [R16] select high swaps roles
    if (pins_s.left_right_sel) begin
      rd_row_nxt = l_ptr;
      rd_valid_nxt = l_valid;
      sh_row_nxt = r_ptr;
      sh_valid_nxt = r_valid;
    end else begin
      rd_row_nxt = r_ptr;
      rd_valid_nxt = r_valid;
      sh_row_nxt = l_ptr;
      sh_valid_nxt = l_valid;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_row_r <= '0;
      sh_row_r <= '0;
      rd_valid_r <= 1'b0;
      sh_valid_r <= 1'b0;
    end else begin
      rd_row_r <= rd_row_nxt;
      sh_row_r <= sh_row_nxt;
      rd_valid_r <= rd_valid_nxt;
      sh_valid_r <= sh_valid_nxt;
    end
  end

  // ----------------------------------------------------------------
  // amplifier, column and data path controls
  // ----------------------------------------------------------------
  always_comb begin
    // [R07] input select
    amp_nxt.ext_sel = pins_s.amp_ext_sel;
    // [R08] gain word
    amp_nxt.gain_word = pins_s.gain_word;
    // [R09] unity overrides gain
    amp_nxt.unity = pins_s.unity_gain;
    // [R10] fast dark calibration
    amp_nxt.fast_cal = pins_s.fast_cal;
    // [R11] slow calibration switches
    amp_nxt.st2_to_dac = pins_s.slow_cal;
    amp_nxt.st1_to_out = pins_s.slow_cal;
    // [R12] black offset word
    amp_nxt.black_offset = pins_s.black_offset;
    // [R13] hold when high
    hold_nxt = pins_s.track_hold;
    // [R14] column calibration
    cal_nxt = pins_s.col_cal;
    // [R15] output inversion
    data_nxt = pins_s.bit_invert ? ~adc_word_i : adc_word_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_r <= '0;
      hold_r <= 1'b0;
      cal_r <= 1'b0;
      data_r <= '0;
    end else begin
      amp_r <= amp_nxt;
      hold_r <= hold_nxt;
      cal_r <= cal_nxt;
      data_r <= data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // write lands on the edge where the master sees ack
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

  always_comb begin
    rd_mux = '0;
    case (wb_adr_i)
      ADR_STATUS: begin
        rd_mux[ST_EOS_POS +: 3] = {c_eos_n, l_eos_n, r_eos_n};
        rd_mux[ST_VALID_POS +: 3] = {c_valid, l_valid, r_valid};
        rd_mux[ST_LR_POS] = pins_s.left_right_sel;
        rd_mux[ST_INV_POS] = pins_s.bit_invert;
      end
      ADR_LAST_ROW: rd_mux[PTR_W-1:0] = last_row_r;
      ADR_LAST_COL: rd_mux[PTR_W-1:0] = last_col_r;
      ADR_ROW_PTR: begin
        rd_mux[PTR_W-1:0] = r_ptr;
        rd_mux[ROWPTR_LEFT_POS +: PTR_W] = l_ptr;
      end
      ADR_COL_PTR: rd_mux[PTR_W-1:0] = c_ptr;
      ADR_AMP: begin
        rd_mux[AMP_GAIN_POS +: 4] = amp_r.gain_word;
        rd_mux[AMP_OFFS_POS +: 4] = amp_r.black_offset;
        rd_mux[AMP_FLAG_POS +: 5] = {amp_r.st1_to_out, amp_r.fast_cal,
                                     amp_r.unity, amp_r.ext_sel, hold_r};
      end
      // unmapped addresses read zero and still ack
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt = ack_nxt ? rd_mux : rdat_r;
    last_row_nxt = last_row_r;
    last_col_nxt = last_col_r;
    if (wr_take && wb_adr_i == ADR_LAST_ROW) begin
      if (wb_sel_i[0]) begin
        last_row_nxt[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        last_row_nxt[PTR_W-1:8] = wb_dat_i[PTR_W-1:8];
      end
    end
    if (wr_take && wb_adr_i == ADR_LAST_COL) begin
      if (wb_sel_i[0]) begin
        last_col_nxt[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        last_col_nxt[PTR_W-1:8] = wb_dat_i[PTR_W-1:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      last_row_r <= LAST_ROW_DEF;
      last_col_r <= LAST_COL_DEF;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      last_row_r <= last_row_nxt;
      last_col_r <= last_col_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  // [R04] [R05] [R06] end-of-scan pins
  assign right_row_end_of_scan_n_o = r_eos_n;
  assign left_row_end_of_scan_n_o = l_eos_n;
  assign col_end_of_scan_n_o = c_eos_n;
  assign right_row_ptr_o = r_ptr;
  assign left_row_ptr_o = l_ptr;
  assign col_ptr_o = c_ptr;
  assign readout_row_o = rd_row_r;
  assign shutter_row_o = sh_row_r;
  assign readout_row_valid_o = rd_valid_r;
  assign shutter_row_valid_o = sh_valid_r;
  assign col_valid_o = c_valid;
  assign amp_o = amp_r;
  assign col_hold_o = hold_r;
  assign col_cal_o = cal_r;
  assign data_word_o = data_r;
endmodule

// ==== verif/isc_ctrl_sva.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// pin behaviour checker
// ----------------------------------------
module isc_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire isc_pkg::isc_pins_s pins_i,
  input wire logic [isc_pkg::ADC_W-1:0] adc_word_i,
  input wire logic right_row_end_of_scan_n_o,
  input wire logic left_row_end_of_scan_n_o,
  input wire logic col_end_of_scan_n_o,
  input wire logic [isc_pkg::PTR_W-1:0] right_row_ptr_o,
  input wire logic [isc_pkg::PTR_W-1:0] col_ptr_o,
  input wire logic col_valid_o,
  input wire isc_pkg::isc_amp_s amp_o,
  input wire logic col_hold_o,
  input wire logic col_cal_o,
  input wire logic [isc_pkg::ADC_W-1:0] data_word_o
);
  import isc_pkg::*;
  // synchronisers need a few edges after reset to flush
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  always_comb begin
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    age_r <= rst_i ? 3'h0 : age_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet;
    (age_r == 3'h7 && $stable(pins_i))[*4];
  endsequence
  sequence s_rsync;
    (!pins_i.right_row_sync_n)[*4];
  endsequence
  sequence s_csync;
    (!pins_i.col_sync_n)[*4];
  endsequence
  AST_ACK_AFTER_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RROW_SYNC: assert property (s_rsync |->
    right_row_ptr_o == '0 && right_row_end_of_scan_n_o)
    else $error("right sync did not clear");
  AST_COL_SYNC: assert property (s_csync |->
    col_ptr_o == '0 && !col_valid_o && col_end_of_scan_n_o)
    else $error("column sync did not clear");
  AST_COL_FIRST: assert property ($rose(col_valid_o) |-> col_ptr_o == '0)
    else $error("first column not zero");
  AST_COL_STEP: assert property (col_valid_o && $changed(col_ptr_o) |->
    col_ptr_o == $past(col_ptr_o) + 11'h1 && !pins_i.col_clock)
    else $error("column step wrong");
  AST_COL_EOS: assert property ($fell(col_end_of_scan_n_o) |->
    (!col_valid_o && !col_end_of_scan_n_o)[*4])
    else $error("column end of scan wrong");
  AST_RROW_EOS: assert property ($fell(right_row_end_of_scan_n_o) |->
    !pins_i.right_row_clock && pins_i.right_row_sync_n)
    else $error("right end of scan off clock");
  AST_LROW_EOS: assert property ($fell(left_row_end_of_scan_n_o) |->
    !pins_i.left_row_clock && pins_i.left_row_sync_n)
    else $error("left end of scan off clock");
  AST_AMP_COPY: assert property (s_quiet |->
    amp_o == {pins_i.amp_ext_sel, pins_i.gain_word, pins_i.unity_gain, pins_i.fast_cal,
    pins_i.slow_cal, pins_i.slow_cal, pins_i.black_offset})
    else $error("amplifier controls wrong");
  AST_COL_COPY: assert property (s_quiet |->
    col_hold_o == pins_i.track_hold && col_cal_o == pins_i.col_cal)
    else $error("column controls wrong");
  AST_INVERT: assert property (s_quiet |=>
    data_word_o == ($past(adc_word_i) ^ {ADC_W{$past(pins_i.bit_invert)}}))
    else $error("output word wrong");
endmodule

bind isc_ctrl_top isc_ctrl_sva isc_ctrl_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pins_i(pins_i),
  .adc_word_i(adc_word_i), .right_row_end_of_scan_n_o(right_row_end_of_scan_n_o),
  .left_row_end_of_scan_n_o(left_row_end_of_scan_n_o),
  .col_end_of_scan_n_o(col_end_of_scan_n_o), .right_row_ptr_o(right_row_ptr_o),
  .col_ptr_o(col_ptr_o), .col_valid_o(col_valid_o), .amp_o(amp_o),
  .col_hold_o(col_hold_o), .col_cal_o(col_cal_o), .data_word_o(data_word_o));

// ==== verif/isc_seq_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// timing sequencer model
// ----------------------------------------
module isc_seq_model (
  input wire logic clk_i,
  output isc_pkg::isc_pins_s pins_o
);
  import isc_pkg::*;
  // pin clocks stand still low between scans
  localparam int HALF = 6;
  initial begin
    pins_o = '0;
    pins_o.right_row_sync_n = 1'b1;
    pins_o.left_row_sync_n = 1'b1;
    pins_o.col_sync_n = 1'b1;
  end
  task automatic sync(input int k);
    @(posedge clk_i);
    if (k == 0) pins_o.right_row_sync_n <= 1'b0;
    else if (k == 1) pins_o.left_row_sync_n <= 1'b0;
    else pins_o.col_sync_n <= 1'b0;
    repeat (HALF) @(posedge clk_i);
    pins_o.right_row_sync_n <= 1'b1;
    pins_o.left_row_sync_n <= 1'b1;
    pins_o.col_sync_n <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask
  // one unbroken row train for both pointers
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (k == 0) begin
        pins_o.right_row_clock <= 1'b1;
        pins_o.left_row_clock <= 1'b1;
      end else pins_o.col_clock <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      pins_o.right_row_clock <= 1'b0;
      pins_o.left_row_clock <= 1'b0;
      pins_o.col_clock <= 1'b0;
      repeat (HALF) @(posedge clk_i);
    end
  endtask
  // words and selects, set between lines
  task automatic set_static(input logic [3:0] g, input logic [3:0] o, input logic [7:0] f);
    @(posedge clk_i);
    pins_o.gain_word <= g;
    pins_o.black_offset <= o;
    {pins_o.left_right_sel, pins_o.amp_ext_sel, pins_o.unity_gain, pins_o.fast_cal,
      pins_o.slow_cal, pins_o.track_hold, pins_o.col_cal, pins_o.bit_invert} <= f;
  endtask
endmodule

// ==== verif/isc_ctrl_top_tb.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// control pins testbench
// ----------------------------------------
module isc_ctrl_top_tb;
  import isc_pkg::*;
  typedef struct packed {
    logic [3:0] g;
    logic [3:0] o;
    logic [7:0] f;
    logic [9:0] adc;
    logic [9:0] dat;
    logic [12:0] amp;
    logic [12:0] reg_v;
  } isc_row_s;
  // flags: sel ext unity fast slow hold cal invert
  isc_row_s rows [4] = '{
    '{4'h1, 4'h8, 8'h44, 10'h2a5, 10'h2a5, 13'h1108, 13'h0381},
    '{4'h8, 4'h1, 8'h33, 10'h0f0, 10'h30f, 13'h08c1, 13'h0c18},
    '{4'hf, 4'h0, 8'h08, 10'h155, 10'h155, 13'h0f30, 13'h100f},
    '{4'h0, 4'hf, 8'h7f, 10'h3ff, 10'h000, 13'h10ff, 13'h1ff0}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat;
  logic [9:0] adc;
  logic [31:0] rdat;
  logic ack, eos_r_n, eos_l_n, eos_c_n, rv, sv, cv, hold, cal;
  logic [10:0] rptr, lptr, cptr, rrow, srow;
  logic [9:0] data;
  isc_amp_s amp;
  isc_pins_s pins;
  int err_count = 0;
  int checks = 0;
  int ncyc = 0;
  isc_seq_model seq_m (.clk_i(clk_i), .pins_o(pins));
  isc_ctrl_top #(.ROWS(3), .COLS(5)) isc_ctrl_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pins), .adc_word_i(adc),
    .right_row_end_of_scan_n_o(eos_r_n), .left_row_end_of_scan_n_o(eos_l_n),
    .col_end_of_scan_n_o(eos_c_n), .right_row_ptr_o(rptr), .left_row_ptr_o(lptr),
    .col_ptr_o(cptr), .readout_row_o(rrow), .shutter_row_o(srow),
    .readout_row_valid_o(rv), .shutter_row_valid_o(sv), .col_valid_o(cv), .amp_o(amp),
    .col_hold_o(hold), .col_cal_o(cal), .data_word_o(data));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // the whole run needs about 340 cycles
  always @(posedge clk_i) begin
    ncyc++;
    if (ncyc == 6000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    req <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'h0, 32'h0, q);
    chk(q, e);
  endtask
  initial begin
    logic [31:0] q;
    req <= 1'b0;
    we <= 1'b0;
    adr <= 8'h00;
    sel <= 4'h0;
    dat <= 32'h0;
    adc <= 10'h000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      seq_m.set_static(rows[i].g, rows[i].o, rows[i].f);
      adc <= rows[i].adc;
      repeat (5) @(posedge clk_i);
      chk(amp, rows[i].amp);
      chk({hold, cal}, rows[i].f[2:1]);
      chk(data, rows[i].dat);
      rd(ADR_AMP, {19'h0, rows[i].reg_v});
      $display("row %0d done", i);
    end
    seq_m.set_static(4'h0, 4'h0, 8'h00);
    adc <= '0;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({amp, hold, cal, data, eos_r_n, eos_l_n, eos_c_n}, {25'h0, 3'b111});
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(ADR_STATUS, 32'h7);
    rd(ADR_LAST_ROW, 32'h2);
    rd(ADR_LAST_COL, 32'h4);
    rd(ADR_ROW_PTR, 32'h0);
    rd(ADR_AMP, 32'h0);
    $display("reset done");
    // lane 0 alone leaves bits 10:8 untouched
    wb(1'b1, ADR_LAST_ROW, 4'h1, 32'h7ff, q);
    rd(ADR_LAST_ROW, 32'h0ff);
    wb(1'b1, ADR_LAST_ROW, 4'h3, 32'h2, q);
    wb(1'b1, ADR_LAST_COL, 4'hf, 32'hffff_f803, q);
    rd(ADR_LAST_COL, 32'h3);
    wb(1'b1, ADR_STATUS, 4'hf, 32'h0, q);
    rd(ADR_STATUS, 32'h7);
    wb(1'b1, 8'h20, 4'hf, 32'hffff_ffff, q);
    rd(8'h20, 32'h0);
    $display("registers done");
    seq_m.sync(2);
    seq_m.pulse(1, 2);
    chk({cv, cptr}, 12'h801);
    seq_m.sync(2);
    chk({cv, cptr}, 12'h0);
    seq_m.pulse(1, 4);
    chk({cv, eos_c_n, cptr}, 13'h1803);
    rd(ADR_COL_PTR, 32'h3);
    seq_m.pulse(1, 1);
    chk({cv, eos_c_n}, 2'b00);
    rd(ADR_STATUS, 32'h3);
    seq_m.pulse(1, 1);
    chk({cv, eos_c_n}, 2'b01);
    $display("column scan done");
    seq_m.sync(0);
    seq_m.pulse(0, 1);
    seq_m.sync(1);
    seq_m.pulse(0, 1);
    chk({rrow, srow, rv, sv}, {11'h1, 11'h0, 2'b11});
    rd(ADR_ROW_PTR, 32'h1);
    seq_m.set_static(4'h0, 4'h0, 8'h80);
    repeat (6) @(posedge clk_i);
    chk({rrow, srow}, {11'h0, 11'h1});
    seq_m.pulse(0, 2);
    chk({eos_r_n, eos_l_n, lptr}, {2'b01, 11'h2});
    seq_m.pulse(0, 1);
    chk({eos_r_n, eos_l_n}, 2'b10);
    seq_m.sync(0);
    chk({eos_r_n, rptr}, 12'h800);
    $display("row scan done");
    results();
  end
endmodule
